// [design/pdio_filt.v]
// One channel of the digital input filter
`timescale 1ns/10ps
`default_nettype none
`include "pdio_map.vh"

module pdio_filt (
    input wire clk_sys,
    input wire arst_n,
    input wire tick,
    input wire en,
    input wire [3:0] sel,
    input wire din,
    output wire dout
);

    reg dout_r;
    reg [15:0] cnt_r;
    wire [15:0] target;
    wire [15:0] cnt_inc;

    assign target = `PDIO_ONE16 << sel;
    assign cnt_inc = cnt_r + `PDIO_ONE16;
    assign dout = dout_r;

    // A change must hold for 2^sel base ticks before it is accepted
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dout_r <= 1'b0;
            cnt_r <= `PDIO_ZERO16;
        end
        else if (!en)
        begin
            dout_r <= din;
            cnt_r <= `PDIO_ZERO16;
        end
        else if (din == dout_r)
        begin
            cnt_r <= `PDIO_ZERO16;
        end
        else if (tick)
        begin
            if (cnt_inc == target)
            begin
                dout_r <= din;
                cnt_r <= `PDIO_ZERO16;
            end
            else
            begin
                cnt_r <= cnt_inc;
            end
        end
    end

endmodule // pdio_filt
`default_nettype wire

// [design/pdio_top.v]
// Sixteen-in, sixteen-out digital I/O port with edge interrupts on APB
`timescale 1ns/10ps
`default_nettype none
`include "pdio_map.vh"

module pdio_top (
    input wire clk_sys,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [4:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] din_pin_i,
    input wire [15:0] dout_pin_i,
    output wire [15:0] dout_pin_o,
    output wire [15:0] dout_pin_oe,
    output wire irq
);

    // Bus slave state
    reg [31:0] prdata_r;
    reg pready_r;
    reg pslverr_r;

    // Software registers
    reg [15:0] out_r;
    reg [15:0] edge_r;
    reg [15:0] mask_r;
    reg [15:0] stat_r;
    reg [15:0] stat_nxt;
    reg [3:0] fsel_r;
    reg fen_r;

    // Pin side
    reg [15:0] din_s1_r;
    reg [15:0] din_s2_r;
    reg [15:0] opin_s1_r;
    reg [15:0] opin_s2_r;
    reg [15:0] oe_r;
    reg [15:0] o_r;
    reg [15:0] prev_r;
    reg irq_r;

    // Filter time base
    reg [8:0] acc_r;
    reg [8:0] acc_nxt;
    reg tick_r;

    // Read path
    reg [31:0] rd_data;
    reg rd_ok;

    wire setup_ph;
    wire done;
    wire wr_done;
    wire rd_done;
    wire [15:0] din_log;
    wire [15:0] filt;
    wire [15:0] rise;
    wire [15:0] fall;
    wire [15:0] ev;
    wire [15:0] clr;
    wire [15:0] pend;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dout_pin_o = o_r;
    assign dout_pin_oe = oe_r;
    assign irq = irq_r;

    // Setup cycle prepares the answer, the following edge completes it
    assign setup_ph = psel & ~penable;
    assign done = psel & penable & pready_r;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;

    // Two-flop synchronisers; pins idle high through the pull-ups
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            din_s1_r <= `PDIO_PIN_IDLE;
            din_s2_r <= `PDIO_PIN_IDLE;
            opin_s1_r <= `PDIO_PIN_IDLE;
            opin_s2_r <= `PDIO_PIN_IDLE;
        end
        else
        begin
            din_s1_r <= din_pin_i;
            din_s2_r <= din_s1_r;
            opin_s1_r <= dout_pin_i;
            opin_s2_r <= opin_s1_r;
        end
    end

    // Low pin reads as logical 1
    assign din_log = ~din_s2_r;

    // Fractional divider: 8 MHz does not divide 250 MHz evenly, so the
    // accumulator spreads the ticks; the average rate is exact
    always @*
    begin
        acc_nxt = acc_r + `PDIO_ACC_STEP;
        if (acc_nxt >= `PDIO_ACC_MOD)
        begin
            acc_nxt = acc_nxt - `PDIO_ACC_MOD;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_r <= `PDIO_ACC_RST;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            tick_r <= (acc_nxt < acc_r);
        end
    end

    // One filter per channel, ahead of edge detection and the read value
    genvar gi;
    generate
        for (gi = 0; gi < `PDIO_NCH; gi = gi + 1)
        begin : g_filt
            pdio_filt u_filt (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .tick(tick_r),
                .en(fen_r),
                .sel(fsel_r),
                .din(din_log[gi]),
                .dout(filt[gi])
            );
        end
    endgenerate

    // Edge detection on the filtered logical level
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev_r <= `PDIO_ZERO16;
        end
        else
        begin
            prev_r <= filt;
        end
    end

    // Logical rising is pin high-to-low, falling is low-to-high
    assign rise = filt & ~prev_r;
    assign fall = ~filt & prev_r;
    // Every channel may be a source; its select bit picks the edge
    assign ev = (rise & edge_r) | (fall & ~edge_r);

    // A read of status clears only the bits it returned, so an event that
    // lands between setup and completion survives to the next read
    assign clr = (rd_done && paddr == `PDIO_A_STAT) ?
        prdata_r[15:0] : `PDIO_ZERO16;

    // Sticky status: a new event wins over the clear
    always @*
    begin
        stat_nxt = (stat_r & ~clr) | ev;
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stat_r <= `PDIO_ZERO16;
        end
        else
        begin
            stat_r <= stat_nxt;
        end
    end

    // Mask bit 1 blocks the channel
    assign pend = stat_nxt & ~mask_r;

    // Single level interrupt, always allocated, from all sixteen channels
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= |pend;
        end
    end

    // Software register writes take effect at the completing edge
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_r <= `PDIO_ZERO16;
            edge_r <= `PDIO_ZERO16;
            mask_r <= `PDIO_ONES16;
            fsel_r <= `PDIO_SEL_RST;
            fen_r <= 1'b0;
        end
        else if (wr_done)
        begin
            case (paddr)
                `PDIO_A_OUT:
                begin
                    out_r <= pwdata[15:0];
                end
                `PDIO_A_EDGE:
                begin
                    edge_r <= pwdata[15:0];
                end
                `PDIO_A_MASK:
                begin
                    mask_r <= pwdata[15:0];
                end
                `PDIO_A_FILT:
                begin
                    fsel_r <= pwdata[`PDIO_F_SEL_HI:`PDIO_F_SEL_LO];
                    fen_r <= pwdata[`PDIO_F_EN];
                end
                default:
                begin
                    fen_r <= fen_r;
                end
            endcase
        end
    end

    // Open collector: a logical 1 enables the pull-down; pin is never driven high
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            oe_r <= `PDIO_ZERO16;
            o_r <= `PDIO_PIN_LOW;
        end
        else
        begin
            oe_r <= out_r;
            o_r <= `PDIO_PIN_LOW;
        end
    end

    // Read multiplexer; unmapped offsets answer zero with an error
    always @*
    begin
        rd_data = `PDIO_ZERO32;
        rd_ok = 1'b1;
        case (paddr)
            `PDIO_A_IN:
            begin
                rd_data[15:0] = filt;
            end
            `PDIO_A_OUT:
            begin
                rd_data[15:0] = out_r;
            end
            `PDIO_A_EDGE:
            begin
                rd_data[15:0] = edge_r;
            end
            `PDIO_A_STAT:
            begin
                rd_data[15:0] = stat_r;
            end
            `PDIO_A_MASK:
            begin
                rd_data[15:0] = mask_r;
            end
            `PDIO_A_FILT:
            begin
                rd_data[`PDIO_F_SEL_HI:`PDIO_F_SEL_LO] = fsel_r;
                rd_data[`PDIO_F_EN] = fen_r;
            end
            `PDIO_A_OPIN:
            begin
                rd_data[15:0] = ~opin_s2_r;
            end
            default:
            begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // One wait-free access phase: ready rises in the cycle after setup
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_r <= `PDIO_ZERO32;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_r <= pwrite ? `PDIO_ZERO32 : rd_data;
            pready_r <= 1'b1;
            pslverr_r <= ~rd_ok;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            if (done)
            begin
                prdata_r <= `PDIO_ZERO32;
            end
        end
    end

endmodule // pdio_top
`default_nettype wire

// [dv/pdio_chk_sva.sv]
// Port-level assertions for the digital I/O port
`timescale 1ns/10ps
`default_nettype none
`include "pdio_map.vh"
module pdio_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] din_pin_i,
    input wire logic [15:0] dout_pin_i,
    input wire logic [15:0] dout_pin_o,
    input wire logic [15:0] dout_pin_oe,
    input wire logic irq
);
    wire logic setup;
    wire logic bad_a;
    // Setup phase and offsets outside the map
    assign setup = psel && !penable;
    assign bad_a = paddr > 5'h18 || paddr[1:0] != 2'b00;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    property p_rdy;
        setup |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_rdy1;
        pready |=> !pready;
    endproperty
    a_rdy1: assert property (p_rdy1) else $error("ready too long");
    property p_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle) else $error("data off");
    property p_hi;
        pready |-> prdata[31:16] == 16'h0000;
    endproperty
    a_hi: assert property (p_hi) else $error("upper half set");
    property p_err;
        setup && bad_a |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_ok;
        setup && !bad_a |=> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("false error");
    property p_o;
        dout_pin_o == 16'h0000;
    endproperty
    a_o: assert property (p_o) else $error("pin driven high");
    property p_oe;
        pready && psel && penable && pwrite && paddr == `PDIO_A_OUT |->
            ##2 {16'h0000, dout_pin_oe} == ($past(pwdata, 2) & 32'h0000_FFFF);
    endproperty
    a_oe: assert property (p_oe) else $error("output mismatch");
    // Only the edge after a completed output write may move the enables
    property p_oes;
        !$past(pready && penable && pwrite && paddr == `PDIO_A_OUT) |=>
            $stable(dout_pin_oe);
    endproperty
    a_oes: assert property (p_oes) else $error("output moved");
endmodule // pdio_chk
bind pdio_top pdio_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din_pin_i(din_pin_i), .dout_pin_i(dout_pin_i),
    .dout_pin_o(dout_pin_o), .dout_pin_oe(dout_pin_oe), .irq(irq));
`default_nettype wire

// [dv/pdio_ext.sv]
// Field wiring model: pulled-up inputs and open-collector output lines
`timescale 1ns/10ps
`default_nettype none
module pdio_ext (
    input wire logic [15:0] pull_lo,
    input wire logic [15:0] oc_oe,
    input wire logic [15:0] oc_o,
    output logic [15:0] in_pin,
    output logic [15:0] out_pin
);
    // A released input floats high through its pull-up
    assign in_pin = ~pull_lo;
    // Line is low only while the transistor conducts, pull-up otherwise
    assign out_pin = (oc_oe & oc_o) | ~oc_oe;
endmodule // pdio_ext
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the digital I/O port
`timescale 1ns/10ps
`default_nettype none
`include "pdio_map.vh"
module tb;
    logic clk_sys, arst_n, psel, penable, pwrite, rde;
    logic [4:0] paddr;
    logic [31:0] pwdata, rdq;
    logic [15:0] pull_r;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq;
    wire logic [15:0] din_pin, dout_pin, pin_o, pin_oe;
    int miscompares = 0;
    int n_checks = 0;
    pdio_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .din_pin_i(din_pin), .dout_pin_i(dout_pin), .dout_pin_o(pin_o),
        .dout_pin_oe(pin_oe), .irq(irq));
    pdio_ext u_ext (.pull_lo(pull_r), .oc_oe(pin_oe), .oc_o(pin_o),
        .in_pin(din_pin), .out_pin(dout_pin));
    // 250 MHz clock
    initial
    begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    task test_done;
        $display("checks=%0d errors=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // One transfer, then an idle cycle so psel is never assigned twice
    task apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rdq = prdata;
        rde = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 20)
        begin
            miscompares++;
            test_done;
        end
        @(posedge clk_sys);
    endtask
    task rd(input logic [4:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        chk(exp, rdq);
    endtask
    task t_regs;
        rd(`PDIO_A_MASK, 32'h0000_FFFF);
        rd(`PDIO_A_EDGE, 0);
        rd(`PDIO_A_IN, 0);
        rd(`PDIO_A_FILT, 0);
        chk(0, irq);
    endtask
    task t_out;
        apb(1, `PDIO_A_OUT, 32'hFFFF_A5C3);
        rd(`PDIO_A_OUT, 32'h0000_A5C3);
        // Enables follow the register one edge late, so look after the read
        chk(16'hA5C3, pin_oe);
        rd(`PDIO_A_OPIN, 32'h0000_A5C3);
    endtask
    task t_err;
        apb(1, 5'h1C, 32'h0000_FFFF);
        chk(1, rde);
        rd(5'h02, 0);
        chk(1, rde);
        apb(1, `PDIO_A_IN, 32'h0000_FFFF);
        rd(`PDIO_A_IN, 0);
    endtask
    // Each channel in turn interrupts on its pin going low
    task t_irq;
        int i;
        apb(1, `PDIO_A_MASK, 0);
        apb(1, `PDIO_A_EDGE, 32'h0000_FFFF);
        for (i = 0; i < 16; i++)
        begin
            pull_r <= 16'h0001 << i;
            repeat (8) @(posedge clk_sys);
            chk(1, irq);
            rd(`PDIO_A_STAT, 32'h0000_0001 << i);
            chk(0, irq);
            pull_r <= 0;
            repeat (8) @(posedge clk_sys);
        end
        rd(`PDIO_A_STAT, 0);
    endtask
    // Logical falling edge selected, interrupt masked
    task t_edge0;
        apb(1, `PDIO_A_EDGE, 0);
        apb(1, `PDIO_A_MASK, 32'h0000_FFFF);
        pull_r <= 16'h8000;
        repeat (8) @(posedge clk_sys);
        rd(`PDIO_A_STAT, 0);
        pull_r <= 0;
        repeat (8) @(posedge clk_sys);
        chk(0, irq);
        rd(`PDIO_A_STAT, 32'h0000_8000);
    endtask
    // n = 3: eight ticks of the 8 MHz base, about 250 clocks
    task t_filt;
        apb(1, `PDIO_A_FILT, 32'h0000_0013);
        pull_r <= 16'h0002;
        repeat (100) @(posedge clk_sys);
        pull_r <= 0;
        repeat (400) @(posedge clk_sys);
        rd(`PDIO_A_IN, 0);
        rd(`PDIO_A_STAT, 0);
        pull_r <= 16'h0002;
        repeat (200) @(posedge clk_sys);
        rd(`PDIO_A_IN, 0);
        repeat (90) @(posedge clk_sys);
        rd(`PDIO_A_IN, 32'h0000_0002);
    endtask
    // Reset in mid-run restores the registers; channel 1 is still held low
    task t_rst;
        apb(1, `PDIO_A_MASK, 0);
        arst_n <= 0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1;
        @(posedge clk_sys);
        chk(0, pin_oe);
        rd(`PDIO_A_MASK, 32'h0000_FFFF);
        rd(`PDIO_A_FILT, 0);
        rd(`PDIO_A_IN, 32'h0000_0002);
    endtask
    // Reset, then the scenarios
    initial
    begin
        arst_n = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
        pull_r = 0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1;
        @(posedge clk_sys);
        t_regs;
        t_out;
        t_err;
        t_irq;
        t_edge0;
        t_filt;
        t_rst;
        test_done;
    end
endmodule // tb
`default_nettype wire

// [inc/pdio_map.vh]
// Address map, field layout, reset values and timing for the digital I/O port
// Overview of operation
// - Every input and output bit is negative logic, a logical 1 being a low pin and a logical 0 a high pin.
// - All sixteen input channels can each raise an interrupt.
// - The interrupt requests of all sixteen inputs merge onto one interrupt output.
// - An input interrupts on its selected edge, the logical rising edge being pin high-to-low and the logical falling edge pin low-to-high.
// - Sixteen open-collector outputs are driven in negative logic, a written 1 turning the transistor on and pulling the pin low.
// - For setting n the input filter time is two to the n periods of an 8 MHz time base.
// - The interrupt line is always allocated, with no strap or switch to disable it.
// - The port is a 32-bit register target that the host reaches with 32-bit transfers.
`ifndef PDIO_MAP_VH
`define PDIO_MAP_VH

// Register byte offsets inside the 32-byte window
`define PDIO_AW 5
`define PDIO_A_IN 5'h00
`define PDIO_A_OUT 5'h04
`define PDIO_A_EDGE 5'h08
`define PDIO_A_STAT 5'h0C
`define PDIO_A_MASK 5'h10
`define PDIO_A_FILT 5'h14
`define PDIO_A_OPIN 5'h18

// Field positions of the filter control register
`define PDIO_F_SEL_HI 3
`define PDIO_F_SEL_LO 0
`define PDIO_F_EN 4

// Widths and reset values
`define PDIO_NCH 16
`define PDIO_ZERO16 16'h0000
`define PDIO_ONES16 16'hFFFF
`define PDIO_ZERO32 32'h0000_0000
`define PDIO_ONE16 16'h0001
`define PDIO_SEL_RST 4'h0
`define PDIO_PIN_IDLE 16'hFFFF
`define PDIO_PIN_LOW 16'h0000

// Filter time base: system clock and base rate in MHz
`define PDIO_CLK_MHZ 250
`define PDIO_TB_MHZ 8
`define PDIO_ACC_W 9
`define PDIO_ACC_STEP 9'h008
`define PDIO_ACC_MOD 9'h0FA
`define PDIO_ACC_RST 9'h000

`endif
